// [shared/ioc_pkg.sv]
package ioc_pkg;
   typedef enum logic [1:0] {
      IOC_COLLECT,
      IOC_CHECK,
      IOC_SEND
   } ioc_state_t;
   typedef logic [15:0] ioc_word_t;
endpackage

// [shared/ioc_regs.svh]
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// ----------------------------------------
// Command codes and error flag
// ----------------------------------------
`define IOC_CMD_GET_COIL 8'h01
`define IOC_CMD_GET_HOLD 8'h03
`define IOC_CMD_GET_INPUT 8'h04
`define IOC_CMD_SET_COIL 8'h0F
`define IOC_CMD_SET_HOLD 8'h10
`define IOC_ERR_FLAG 8'h80

// ----------------------------------------
// Error codes
// ----------------------------------------
`define IOC_ERR_FUNCTION 8'h01
`define IOC_ERR_ADDRESS 8'h02
`define IOC_ERR_VALUE 8'h03
`define IOC_ERR_FAILURE 8'h04

// ----------------------------------------
// Register space, frame layout
// ----------------------------------------
`define IOC_NUM_REGS 16'h0008
`define IOC_COIL_BASE 16'h1801
`define IOC_HOLD_BASE 16'h1841
`define IOC_INPUT_BASE 16'h0864
`define IOC_POS_CMD 8'h00
`define IOC_POS_START_HI 8'h01
`define IOC_POS_START_LO 8'h02
`define IOC_POS_COUNT_HI 8'h03
`define IOC_POS_COUNT_LO 8'h04
`define IOC_POS_LEN 8'h05
`define IOC_POS_PAYLOAD 8'h06
`define IOC_GET_FRAME_LEN 8'h05
`define IOC_SET_RESP_LEN 8'h05
`define IOC_ERR_RESP_LEN 8'h02
`define IOC_BYTE_MAX 8'hFF

`endif

// [sim/ioc_host.sv]
module ioc_host (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Command side
   output logic [7:0] rxData,
   output logic rxValid,
   output logic rxLast,
   input wire logic rxReady,
   // Response side
   output logic txReady,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txLast
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cmdQ[$];
   logic [7:0] respQ[$];
   int slow = 0;
   int nDone = 0;
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      rxLast = 1'b0;
      txReady = 1'b1;
   end
   always @(posedge clk) begin
      automatic logic took = rxValid && rxReady && !srst;
      automatic logic got = txValid && txReady && !srst;
      automatic logic [7:0] d = txData;
      automatic logic l = txLast;
      #1;
      if (took) void'(cmdQ.pop_front());
      if (got) respQ.push_back(d);
      if (got && l) nDone++;
      // Whole frame back to back, never split
      rxValid = cmdQ.size() > 0;
      rxLast = cmdQ.size() == 1;
      // Idle data toggles so a stale byte is never mistaken for a fresh one
      rxData = rxValid ? cmdQ[0] : ~rxData;
      txReady = slow == 0 || $urandom_range(2) == 0;
   end
endmodule

// [sim/ioc_props.sv]
module ioc_props (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Command bytes
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic rxLast,
   input wire logic rxReady,
   // Response bytes
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txLast,
   input wire logic txReady
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic midFrame;
   logic errReply;
   logic [7:0] cmd;
   logic [7:0] lenByte;
   int beats;
   wire rxTake = rxValid && rxReady;
   wire txTake = txValid && txReady;
   always_ff @(posedge clk) begin
      if (srst) midFrame <= 1'b0;
      else if (rxTake) midFrame <= !rxLast;
   end
   always_ff @(posedge clk) if (rxTake && !midFrame) cmd <= rxData;
   always_ff @(posedge clk) begin
      if (srst || !txValid) beats <= 0;
      else if (txTake) beats <= beats + 1;
   end
   always_ff @(posedge clk) if (txTake && beats == 1) lenByte <= txData;
   always_ff @(posedge clk) if (txValid && beats == 0) errReply <= txData[7];
   property p_busy; rxTake && rxLast |=> !rxReady; endproperty
   a_busy: assert property (p_busy) else $error("rxReady high after last byte");
   // Check cycle, then the load cycle, then the first byte stands
   property p_answer; rxTake && rxLast |=> !txValid ##1 !txValid ##1 txValid; endproperty
   a_answer: assert property (p_answer) else $error("reply not two cycles on");
   property p_echo; $rose(txValid) |-> txData[6:0] == cmd[6:0]; endproperty
   a_echo: assert property (p_echo) else $error("reply code not echoed");
   property p_hold;
      txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast);
   endproperty
   a_hold: assert property (p_hold) else $error("reply byte changed while stalled");
   property p_alone; txValid |-> !rxReady; endproperty
   a_alone: assert property (p_alone) else $error("command taken during reply");
   property p_release; txTake && txLast |=> !txValid && rxReady; endproperty
   a_release: assert property (p_release) else $error("no release after reply");
   property p_errlen; txTake && txLast && errReply |-> beats == 1; endproperty
   a_errlen: assert property (p_errlen) else $error("error reply not two bytes");
   property p_getlen;
      txTake && txLast && !errReply && cmd < 8'h05 |-> beats == lenByte + 1;
   endproperty
   a_getlen: assert property (p_getlen) else $error("read reply length wrong");
   property p_setlen; txTake && txLast && !errReply && cmd > 8'h05 |-> beats == 4; endproperty
   a_setlen: assert property (p_setlen) else $error("write reply length wrong");
   c_err: cover property (txTake && txLast && errReply);
   c_get: cover property (txTake && txLast && !errReply && cmd < 8'h05);
   c_stall: cover property (txValid && !txReady);
   c_set: cover property (txTake && txLast && !errReply && cmd > 8'h05);
endmodule

// [sim/tb.sv]
`define CHECK_EQ(what, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
   $display("FAIL %s expected %0h seen %0h", what, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] rxData, txData, coilOut;
   logic rxValid, rxLast, rxReady, txValid, txLast, txReady;
   logic [127:0] inputRegs = '0;
   logic [127:0] holdOut;
   logic [7:0] mCoil = 8'h00;
   logic [15:0] mHold[8] = '{default: 16'h0000};
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   ioc_interpreter ioc_interpreter_inst (.clk(clk), .srst(srst), .rxData(rxData),
      .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady), .txData(txData),
      .txValid(txValid), .txLast(txLast), .txReady(txReady), .inputRegs(inputRegs),
      .coilOut(coilOut), .holdOut(holdOut));
   ioc_host ioc_host_inst (.clk(clk), .srst(srst), .rxData(rxData), .rxValid(rxValid),
      .rxLast(rxLast), .rxReady(rxReady), .txReady(txReady), .txData(txData),
      .txValid(txValid), .txLast(txLast));
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end
   function automatic logic [15:0] baseOf(input logic [7:0] c);
      return c == 8'h01 || c == 8'h0F ? 16'h1801 : c == 8'h04 ? 16'h0864 : 16'h1841;
   endfunction
   // Reference model: updates model state and builds the expected reply
   function automatic void model(input logic [7:0] f[$], output logic [7:0] r[$]);
      logic [7:0] c = f[0];
      int cnt = {f[3], f[4]};
      int off = int'({f[1], f[2]}) - int'(baseOf(f[0]));
      int e = 0;
      logic [15:0] w;
      if (!(c inside {8'h01, 8'h03, 8'h04, 8'h0F, 8'h10})) e = 1;
      else if (cnt == 0 || cnt > 8) e = 3;
      else if (off < 0 || off + cnt > 8) e = 2;
      else if (c < 8'h05 ? f.size() != 5 : f.size() != 6 + f[5]) e = 3;
      else if (c > 8'h05 && f[5] != (c == 8'h0F ? 1 : 2 * cnt)) e = 3;
      if (e != 0) r = {c | 8'h80, 8'(e)};
      else if (c > 8'h05) r = f[0:4];
      else r = {c, c == 8'h01 ? 8'h01 : 8'(2 * cnt)};
      if (e == 0 && c == 8'h01) r.push_back(8'((int'(mCoil) >> off) & ((1 << cnt) - 1)));
      for (int i = 0; e == 0 && i < cnt; i++) begin
         if (c == 8'h0F) mCoil[off + i] = f[6][i];
         if (c == 8'h10) mHold[off + i] = {f[6 + 2 * i], f[7 + 2 * i]};
         w = c == 8'h03 ? mHold[off + i] : inputRegs[16 * (off + i) +: 16];
         if (c == 8'h03 || c == 8'h04) r = {r, w[15:8], w[7:0]};
      end
   endfunction
   initial begin
      static logic [7:0] codes[6] = '{8'h01, 8'h03, 8'h04, 8'h0F, 8'h10, 8'h05};
      logic [7:0] f[$];
      logic [7:0] exp[$];
      logic [127:0] hExp;
      logic [15:0] st;
      int cnt;
      int n0;
      void'($urandom(77217));
      repeat (3) @(posedge clk);
      #1 srst = 1'b0;
      for (int t = 0; t < 90; t++) begin
         cnt = $urandom_range(9);
         st = baseOf(codes[t % 6]) + 16'($urandom_range(8)) - 16'h0001;
         f = {codes[t % 6], st[15:8], st[7:0], 8'h00, 8'(cnt)};
         if (f[0] > 8'h05) f.push_back(f[0] == 8'h0F ? 8'h01 : 8'(2 * cnt));
         if (f[0] > 8'h05) repeat (f[5]) f.push_back(8'($urandom));
         if (t % 9 == 8) f.push_back(8'h5A);
         inputRegs = {$urandom, $urandom, $urandom, $urandom};
         ioc_host_inst.slow = t % 2;
         model(f, exp);
         n0 = ioc_host_inst.nDone;
         ioc_host_inst.respQ = {};
         ioc_host_inst.cmdQ = f;
         for (int k = 0; k < 300 && ioc_host_inst.nDone == n0; k++) @(posedge clk);
         #1;
         `CHECK_EQ("replyLength", exp.size(), ioc_host_inst.respQ.size());
         foreach (exp[i]) `CHECK_EQ("replyByte", exp[i], ioc_host_inst.respQ[i]);
         foreach (mHold[i]) hExp[16 * i +: 16] = mHold[i];
         `CHECK_EQ("coilOut", mCoil, coilOut);
         `CHECK_EQ("holdOut", hExp, holdOut);
      end
      conclude();
   end
endmodule
bind ioc_interpreter ioc_props ioc_props_inst (.clk(clk), .srst(srst), .rxData(rxData),
   .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady), .txData(txData),
   .txValid(txValid), .txLast(txLast), .txReady(txReady));

// [src/ioc_interpreter.sv]
`include "ioc_regs.svh"

module ioc_interpreter (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Command bytes in
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic rxLast,
   output logic rxReady,
   // Response bytes out
   output logic [7:0] txData,
   output logic txValid,
   output logic txLast,
   input wire logic txReady,
   // Channel registers
   input wire logic [127:0] inputRegs,
   output logic [7:0] coilOut,
   output logic [127:0] holdOut
);
   ioc_pkg::ioc_state_t state;
   logic [7:0] cmd;
   logic [15:0] start;
   logic [15:0] count;
   logic [7:0] len;
   logic [7:0] rxCnt;
   logic [7:0] stageCoil;
   ioc_pkg::ioc_word_t stage [0:7];
   ioc_pkg::ioc_word_t hold [0:7];
   logic [7:0] coil;
   logic isErr;
   logic [7:0] errCode;
   logic [7:0] respLen;
   logic [7:0] txIdx;
   logic [7:0] next_errCode;
   logic [15:0] off;
   logic [7:0] dataLen;
   logic rxTake;
   logic txTake;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Whole window must sit inside one class
   function automatic logic rangeOk(input logic [15:0] s, input logic [15:0] c,
                                    input logic [15:0] base);
      logic [16:0] top;
      top = {1'b0, s} + {1'b0, c};
      rangeOk = (s >= base) && (top <= ({1'b0, base} + {1'b0, `IOC_NUM_REGS}));
   endfunction

   function automatic logic isCoilCmd(input logic [7:0] c);
      isCoilCmd = (c == `IOC_CMD_GET_COIL) || (c == `IOC_CMD_SET_COIL);
   endfunction

   function automatic logic [15:0] baseOf(input logic [7:0] c);
      case (c)
         `IOC_CMD_GET_COIL, `IOC_CMD_SET_COIL: baseOf = `IOC_COIL_BASE;
         `IOC_CMD_GET_INPUT: baseOf = `IOC_INPUT_BASE;
         default: baseOf = `IOC_HOLD_BASE;
      endcase
   endfunction

   assign rxReady = (state == ioc_pkg::IOC_COLLECT);
   assign rxTake = rxValid && rxReady;
   assign txTake = txValid && txReady;
   assign off = start - baseOf(cmd);
   // Coil data packs eight per byte; registers take two bytes each
   assign dataLen = isCoilCmd(cmd) ? 8'h01 : {count[6:0], 1'b0};

   // ----------------------------------------
   // Frame checking
   // ----------------------------------------
   always_comb begin
      next_errCode = 8'h00;
      if (!(cmd == `IOC_CMD_GET_COIL || cmd == `IOC_CMD_GET_HOLD ||
            cmd == `IOC_CMD_GET_INPUT || cmd == `IOC_CMD_SET_COIL ||
            cmd == `IOC_CMD_SET_HOLD)) begin
         next_errCode = `IOC_ERR_FUNCTION;
      end else if (count == 16'h0000 || count > `IOC_NUM_REGS) begin
         next_errCode = `IOC_ERR_VALUE;
      end else if (!rangeOk(start, count, baseOf(cmd))) begin
         next_errCode = `IOC_ERR_ADDRESS;
      end else if (cmd == `IOC_CMD_GET_COIL || cmd == `IOC_CMD_GET_HOLD ||
                   cmd == `IOC_CMD_GET_INPUT) begin
         if (rxCnt != `IOC_GET_FRAME_LEN) begin
            next_errCode = `IOC_ERR_VALUE;
         end
      end else if (len != dataLen || rxCnt != `IOC_POS_PAYLOAD + len) begin
         next_errCode = `IOC_ERR_VALUE;
      end
   end

   // ----------------------------------------
   // Response byte selection
   // ----------------------------------------
   function automatic logic [7:0] respByte(input logic [7:0] idx);
      logic [15:0] k;
      logic [15:0] r;
      logic [7:0] mask;
      ioc_pkg::ioc_word_t w;
      k = {8'h00, idx} - 16'h0002;
      r = off + {1'b0, k[15:1]};
      mask = 8'hFF >> (4'h8 - count[3:0]);
      w = (cmd == `IOC_CMD_GET_INPUT) ? inputRegs[r[2:0]*16 +: 16] : hold[r[2:0]];
      respByte = 8'h00;
      if (idx == `IOC_POS_CMD) begin
         respByte = isErr ? (cmd | `IOC_ERR_FLAG) : cmd;
      end else if (isErr) begin
         respByte = errCode;
      end else if (cmd == `IOC_CMD_SET_COIL || cmd == `IOC_CMD_SET_HOLD) begin
         case (idx)
            `IOC_POS_START_HI: respByte = start[15:8];
            `IOC_POS_START_LO: respByte = start[7:0];
            `IOC_POS_COUNT_HI: respByte = count[15:8];
            default: respByte = count[7:0];
         endcase
      end else if (idx == `IOC_POS_START_HI) begin
         respByte = dataLen;
      end else if (isCoilCmd(cmd)) begin
         respByte = (coil >> off[2:0]) & mask;
      end else begin
         respByte = k[0] ? w[7:0] : w[15:8];
      end
   endfunction

   // ----------------------------------------
   // Control
   // ----------------------------------------
   // Frame boundary comes from rxLast, so a short or long block is
   // answered with a value error instead of desynchronising
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= ioc_pkg::IOC_COLLECT;
      end else begin
         case (state)
            ioc_pkg::IOC_COLLECT: if (rxTake && rxLast) state <= ioc_pkg::IOC_CHECK;
            ioc_pkg::IOC_CHECK: state <= ioc_pkg::IOC_SEND;
            ioc_pkg::IOC_SEND: if (txTake && txLast) state <= ioc_pkg::IOC_COLLECT;
            default: state <= ioc_pkg::IOC_COLLECT;
         endcase
      end
   end

   // ----------------------------------------
   // Command capture
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cmd <= 8'h00;
         start <= 16'h0000;
         count <= 16'h0000;
         len <= 8'h00;
         rxCnt <= 8'h00;
         stageCoil <= 8'h00;
         for (int i = 0; i < 8; i++) stage[i] <= 16'h0000;
      end else if (rxTake) begin
         if (rxCnt != `IOC_BYTE_MAX) rxCnt <= rxCnt + 8'h01;
         case (rxCnt)
            `IOC_POS_CMD: cmd <= rxData;
            `IOC_POS_START_HI: start[15:8] <= rxData;
            `IOC_POS_START_LO: start[7:0] <= rxData;
            `IOC_POS_COUNT_HI: count[15:8] <= rxData;
            `IOC_POS_COUNT_LO: count[7:0] <= rxData;
            `IOC_POS_LEN: len <= rxData;
            default: begin
               if (rxCnt == `IOC_POS_PAYLOAD) stageCoil <= rxData;
               if (rxCnt - `IOC_POS_PAYLOAD < 8'h10) begin
                  if (rxCnt[0]) stage[rxCnt[3:1] - 3'h3][7:0] <= rxData;
                  else stage[rxCnt[3:1] - 3'h3][15:8] <= rxData;
               end
            end
         endcase
      end else if (state == ioc_pkg::IOC_SEND) begin
         rxCnt <= 8'h00;
      end
   end

   // ----------------------------------------
   // Channel registers, written only on a clean frame
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         coil <= 8'h00;
         for (int i = 0; i < 8; i++) hold[i] <= 16'h0000;
      end else if (state == ioc_pkg::IOC_CHECK && next_errCode == 8'h00) begin
         for (int i = 0; i < 8; i++) begin
            if (i >= off && i < off + count) begin
               if (cmd == `IOC_CMD_SET_COIL) coil[i] <= stageCoil[i - off];
               if (cmd == `IOC_CMD_SET_HOLD) hold[i] <= stage[i - off];
            end
         end
      end
   end

   always_comb begin
      coilOut = coil;
      for (int i = 0; i < 8; i++) holdOut[i*16 +: 16] = hold[i];
   end

   // ----------------------------------------
   // Response sequencing
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         isErr <= 1'b0;
         errCode <= 8'h00;
         respLen <= 8'h00;
      end else if (state == ioc_pkg::IOC_CHECK) begin
         isErr <= (next_errCode != 8'h00);
         errCode <= next_errCode;
         if (next_errCode != 8'h00) respLen <= `IOC_ERR_RESP_LEN;
         else if (cmd == `IOC_CMD_SET_COIL || cmd == `IOC_CMD_SET_HOLD)
            respLen <= `IOC_SET_RESP_LEN;
         else respLen <= dataLen + `IOC_POS_START_LO;
      end
   end

   // First byte loads one cycle after CHECK, once isErr has settled
   always_ff @(posedge clk) begin
      if (srst) begin
         txIdx <= 8'h00;
         txValid <= 1'b0;
         txData <= 8'h00;
         txLast <= 1'b0;
      end else if (state == ioc_pkg::IOC_SEND && !txValid) begin
         txValid <= 1'b1;
         txData <= respByte(8'h00);
         txLast <= (respLen == 8'h01);
         txIdx <= 8'h00;
      end else if (txTake) begin
         txIdx <= txIdx + 8'h01;
         txData <= respByte(txIdx + 8'h01);
         txLast <= (txIdx + 8'h02 == respLen);
         if (txLast) txValid <= 1'b0;
      end
   end
endmodule
